/* design/mth_pkg.sv */
// Package: constants, register map and state types of the trip history block
package mth_pkg;
  // Bus and data widths
  localparam int DW = 16;
  localparam int AW = 10;
  // Register indices, byte address is four times the index
  localparam logic [7:0] IDX_SPD_INT = 8'h00;
  localparam logic [7:0] IDX_SPD_LO = 8'h3a;
  localparam logic [7:0] IDX_SPD_HI = 8'h3b;
  localparam logic [7:0] IDX_SPD_MATCH = 8'h44;
  localparam logic [7:0] IDX_SCALE_NUM = 8'h47;
  localparam logic [7:0] IDX_SCALE_DEN = 8'h48;
  localparam logic [7:0] IDX_HIST_CLR = 8'h4a;
  localparam logic [7:0] IDX_HIST1 = 8'h4b;
  localparam logic [7:0] IDX_HIST5 = 8'h4f;
  localparam logic [7:0] IDX_UV_SEL = 8'h50;
  localparam logic [7:0] IDX_RT_SEL = 8'h51;
  localparam logic [7:0] IDX_RT_TIME = 8'h52;
  localparam logic [7:0] IDX_INIT_SEL = 8'h54;
  localparam logic [7:0] IDX_COPY = 8'h57;
  localparam logic [7:0] IDX_IRQ_ST = 8'h60;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h61;
  localparam logic [7:0] IDX_STATUS = 8'h62;
  localparam logic [7:0] IDX_CTRL = 8'h63;
  localparam logic [7:0] IDX_SCL0 = 8'h64;
  localparam logic [7:0] IDX_SCL3 = 8'h67;
  // Status register bit positions
  localparam int ST_TRIP = 0;
  localparam int ST_COAST = 1;
  localparam int ST_SCALE_OK = 2;
  localparam int ST_CAUSE_LSB = 4;
  // Control register: bit 0 clears a latched trip
  localparam int CTRL_TRIP_RST = 0;
  // Interrupt bit positions
  localparam int IRQ_TRIP = 0;
  localparam int IRQ_RETRY = 1;
  localparam int IRQ_UV = 2;
  localparam int IRQ_HCLR = 3;
  // Trip cause codes
  localparam logic [3:0] CAUSE_NONE = 4'h0;
  localparam logic [3:0] CAUSE_OC = 4'h1;
  localparam logic [3:0] CAUSE_UV = 4'h2;
  localparam logic [15:0] HIST_EMPTY = 16'h00ff;
  // Copy selections
  localparam logic [1:0] COPY_NONE = 2'h0;
  localparam logic [1:0] COPY_KP_INIT = 2'h1;
  localparam logic [1:0] COPY_LOAD = 2'h2;
  localparam logic [1:0] COPY_PROG = 2'h3;
  // Factory defaults
  localparam logic [15:0] DEF_SPD_INT = 16'h0000;
  localparam logic [15:0] DEF_SPD_LO = 16'h0000;
  localparam logic [15:0] DEF_SPD_HI = 16'h0bb8;
  localparam logic [15:0] DEF_SPD_MATCH = 16'h000a;
  localparam logic [15:0] DEF_SCALE = 16'h0001;
  localparam logic [6:0] DEF_RT_TIME = 7'h01;
  // Scale factor range: 10 down to 1/1000
  localparam logic [31:0] SCALE_MAX = 32'h0000_000a;
  localparam logic [31:0] SCALE_MIN_DIV = 32'h0000_03e8;
  // Retrial wait in seconds, clock period in ns
  localparam logic [6:0] RT_MIN_S = 7'h01;
  localparam logic [6:0] RT_MAX_S = 7'h78;
  localparam int SEC_NS = 1000000000;
  localparam int CLK_NS = 100;
  localparam int SEC_CYCLES = SEC_NS / CLK_NS;
  // Divider steps for a 32-bit dividend
  localparam logic [5:0] DIV_STEPS = 6'h20;

  typedef enum logic [0:0] {SC_IDLE, SC_WAIT} mth_scan_t;

  typedef struct packed {
    logic busy;
    logic done;
    logic [5:0] cnt;
    logic [16:0] rem;
    logic [31:0] quo;
    logic [15:0] den;
    logic [15:0] res;
  } mth_div_t;

  typedef struct packed {
    logic [3:0][15:0] spd;
    logic [3:0][15:0] scl;
    logic [15:0] num;
    logic [15:0] den;
    logic hclr;
    logic uvsel;
    logic rtsel;
    logic init;
    logic [6:0] rtime;
    logic [1:0] copy;
    logic [4:0][3:0] hcode;
    logic [4:0] hval;
    logic trip;
    logic [3:0] cause;
    logic uv_log;
    logic uv_q;
    logic coast;
    logic motor_en;
    logic pwr_lost;
    logic prm_rst;
    logic [6:0] rt_sec;
    logic [23:0] tick;
    logic [3:0] irq_st;
    logic [3:0] irq_mask;
    logic irq;
    logic [15:0] rdata;
    mth_scan_t scan;
    logic [1:0] sidx;
    logic start;
  } mth_state_t;
endpackage

/* design/mth_scale_if.sv */
// Interface: request and answer between the trip block and its scaler
`timescale 1ns/1ns
interface mth_scale_if;
  logic start;
  logic [15:0] value;
  logic [15:0] num;
  logic [15:0] den;
  logic done;
  logic [15:0] result;
  modport ctrl (output start, output value, output num, output den,
    input done, input result);
  modport calc (input start, input value, input num, input den,
    output done, output result);
endinterface

/* design/mth_scaler.sv */
// Scaler: value times numerator over denominator, one bit per cycle
`timescale 1ns/1ns
module mth_scaler
  import mth_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  mth_scale_if.calc s
);
  mth_div_t q;
  mth_div_t d;
  logic [16:0] rsh;
  logic [31:0] qsh;

  // Restoring division of the product
  always_comb begin
    d = q;
    d.done = 1'b0;
    rsh = {q.rem[15:0], q.quo[31]};
    qsh = {q.quo[30:0], 1'b0};
    if (!q.busy && s.start) begin
      d.busy = 1'b1;
      d.cnt = DIV_STEPS;
      d.rem = '0;
      d.quo = 32'(s.value) * 32'(s.num);
      d.den = s.den;
    end else if (q.busy) begin
      if (rsh >= {1'b0, q.den}) begin
        rsh = rsh - {1'b0, q.den};
        qsh[0] = 1'b1;
      end
      d.rem = rsh;
      d.quo = qsh;
      d.cnt = q.cnt - 6'h01;
      if (q.cnt == 6'h01) begin
        d.busy = 1'b0;
        d.done = 1'b1;
        d.res = (qsh[31:16] != 16'h0000) ? 16'hffff : qsh[15:0]; // Saturate
      end
    end
  end

  // State register
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign s.done = q.done;
  assign s.result = q.res;
endmodule

/* design/mth_trip_ctrl.sv */
// Trip history, undervoltage, retrial, display scaling and power-cycle actions
//
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ns
module mth_trip_ctrl
  import mth_pkg::*;
#(
  parameter int P_SEC_CYCLES = SEC_CYCLES
)
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [AW-1:0] i_addr,
  input wire logic [DW-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [DW-1:0] o_rdata,
  input wire logic i_uv,
  input wire logic i_run_cmd,
  input wire logic i_trip_evt,
  input wire logic [3:0] i_trip_code,
  input wire logic i_pwr_off,
  input wire logic i_pwr_on,
  output logic o_trip,
  output logic o_coast,
  output logic o_motor_en,
  output logic o_prm_rst,
  output logic [1:0] o_copy_mode,
  output logic o_irq
);
  mth_state_t q;
  mth_state_t d;
  mth_scale_if sc ();

  logic [7:0] widx;
  logic [7:0] ridx;
  logic scale_ok;
  logic scale_on;
  logic [6:0] rt_lim;
  logic [3:0] ev;
  logic [2:0] hsel;
  logic [15:0] rval;
  logic push;
  logic [3:0] push_code;
  logic [4:0][3:0] hcode_sh;
  logic [4:0] hval_sh;
  logic [3:0][15:0] shown;

  mth_scaler u_scaler (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .s(sc.calc)
  );

  // Scaler request from the state record
  assign sc.start = q.start;
  assign sc.value = q.spd[q.sidx];
  assign sc.num = q.num;
  assign sc.den = q.den;

  assign widx = i_addr[9:2];
  assign ridx = i_addr[9:2];

  assign scale_ok = (q.den != 16'h0000)
    && (32'(q.num) <= 32'(q.den) * SCALE_MAX)
    && (32'(q.num) * SCALE_MIN_DIV >= 32'(q.den));
  assign scale_on = scale_ok && (q.num != q.den);

  assign rt_lim = (q.rtime < RT_MIN_S) ? RT_MIN_S
    : ((q.rtime > RT_MAX_S) ? RT_MAX_S : q.rtime);

  // History shifted by one entry, new cause in entry one
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_hist
      if (gi == 0) begin : g_new
        assign hcode_sh[gi] = push_code;
        assign hval_sh[gi] = 1'b1;
      end else begin : g_old
        assign hcode_sh[gi] = q.hcode[gi-1];
        assign hval_sh[gi] = q.hval[gi-1];
      end
    end
    for (gi = 0; gi < 4; gi++) begin : g_show
      assign shown[gi] = scale_on ? q.scl[gi] : q.spd[gi];
    end
  endgenerate

  // Read data mux
  always_comb begin
    rval = 16'h0000;
    hsel = 3'(ridx - IDX_HIST1);
    if (ridx == IDX_SPD_INT) begin
      rval = shown[0];
    end else if (ridx == IDX_SPD_LO) begin
      rval = shown[1];
    end else if (ridx == IDX_SPD_HI) begin
      rval = shown[2];
    end else if (ridx == IDX_SPD_MATCH) begin
      rval = shown[3];
    end else if (ridx == IDX_SCALE_NUM) begin
      rval = q.num;
    end else if (ridx == IDX_SCALE_DEN) begin
      rval = q.den;
    end else if (ridx == IDX_HIST_CLR) begin
      rval = 16'(q.hclr);
    end else if (ridx >= IDX_HIST1 && ridx <= IDX_HIST5) begin
      rval = q.hval[hsel] ? 16'(q.hcode[hsel]) : HIST_EMPTY;
    end else if (ridx == IDX_UV_SEL) begin
      rval = 16'(q.uvsel);
    end else if (ridx == IDX_RT_SEL) begin
      rval = 16'(q.rtsel);
    end else if (ridx == IDX_RT_TIME) begin
      rval = 16'(q.rtime);
    end else if (ridx == IDX_INIT_SEL) begin
      rval = 16'(q.init);
    end else if (ridx == IDX_COPY) begin
      rval = 16'(q.copy);
    end else if (ridx == IDX_IRQ_ST) begin
      rval = 16'(q.irq_st);
    end else if (ridx == IDX_IRQ_MASK) begin
      rval = 16'(q.irq_mask);
    end else if (ridx == IDX_STATUS) begin
      rval[ST_TRIP] = q.trip;
      rval[ST_COAST] = q.coast;
      rval[ST_SCALE_OK] = scale_ok;
      rval[ST_CAUSE_LSB +: 4] = q.cause;
    end else if (ridx >= IDX_SCL0 && ridx <= IDX_SCL3) begin
      rval = q.scl[2'(ridx - IDX_SCL0)];
    end
  end

  // Next state of the whole block
  always_comb begin
    d = q;
    ev = 4'h0;
    push = 1'b0;
    push_code = CAUSE_NONE;
    d.start = 1'b0;
    d.prm_rst = 1'b0;
    d.rdata = i_rd ? rval : 16'h0000;
    d.uv_q = i_uv;

    // Register writes
    if (i_wr) begin
      if (widx == IDX_SPD_INT) begin
        d.spd[0] = i_wdata;
      end else if (widx == IDX_SPD_LO) begin
        d.spd[1] = i_wdata;
      end else if (widx == IDX_SPD_HI) begin
        d.spd[2] = i_wdata;
      end else if (widx == IDX_SPD_MATCH) begin
        d.spd[3] = i_wdata;
      end else if (widx == IDX_SCALE_NUM) begin
        d.num = i_wdata;
      end else if (widx == IDX_SCALE_DEN) begin
        d.den = i_wdata;
      end else if (widx == IDX_HIST_CLR) begin
        d.hclr = i_wdata[0];
      end else if (widx == IDX_UV_SEL) begin
        d.uvsel = i_wdata[0];
      end else if (widx == IDX_RT_SEL) begin
        d.rtsel = i_wdata[0];
      end else if (widx == IDX_RT_TIME) begin
        d.rtime = i_wdata[6:0];
      end else if (widx == IDX_INIT_SEL) begin
        d.init = i_wdata[0];
      end else if (widx == IDX_COPY) begin
        d.copy = i_wdata[1:0];
      end else if (widx == IDX_IRQ_MASK) begin
        d.irq_mask = i_wdata[3:0];
      end else if (widx == IDX_CTRL) begin
        if (i_wdata[CTRL_TRIP_RST]) begin
          d.trip = 1'b0;
        end
      end
    end

    // Undervoltage entry
    if (i_uv && !q.uv_q) begin
      ev[IRQ_UV] = 1'b1;
      if (q.uvsel) begin
        if (!q.trip) begin
          d.trip = 1'b1;
          d.cause = CAUSE_UV;
          d.uv_log = 1'b1;
          d.rt_sec = 7'h00;
          d.tick = 24'h00_0000;
          ev[IRQ_TRIP] = 1'b1;
        end
      end else begin
        d.coast = 1'b1;
      end
    end

    // Supply recovery
    if (!i_uv && q.uv_q) begin
      d.coast = 1'b0;
    end

    // External protection trips, logged at once
    if (i_trip_evt && !q.trip && !(i_uv && !q.uv_q && q.uvsel)) begin
      d.trip = 1'b1;
      d.cause = i_trip_code;
      d.rt_sec = 7'h00;
      d.tick = 24'h00_0000;
      push = 1'b1;
      push_code = i_trip_code;
      ev[IRQ_TRIP] = 1'b1;
    end else if (!i_uv && q.uv_q && q.uv_log) begin
      // log only after a brief dip
      push = 1'b1;
      push_code = CAUSE_UV;
      d.uv_log = 1'b0;
    end

    if (push) begin
      d.hcode = hcode_sh;
      d.hval = hval_sh;
    end

    // Retrial timer
    if (q.trip && q.rtsel && q.cause != CAUSE_OC) begin
      if (q.tick == 24'(P_SEC_CYCLES - 1)) begin
        d.tick = 24'h00_0000;
        d.rt_sec = q.rt_sec + 7'h01;
        if (q.rt_sec + 7'h01 >= rt_lim) begin
          d.trip = 1'b0;
          d.rt_sec = 7'h00;
          ev[IRQ_RETRY] = 1'b1;
        end
      end else begin
        d.tick = q.tick + 24'h00_0001;
      end
    end else begin
      d.tick = 24'h00_0000;
      d.rt_sec = 7'h00;
    end

    // Power removed after display went dark
    if (i_pwr_off) begin
      d.pwr_lost = 1'b1;
      d.uv_log = 1'b0;
    end

    // Power back on: pending actions
    if (i_pwr_on && q.pwr_lost) begin
      d.pwr_lost = 1'b0;
      if (q.hclr) begin
        d.hval = 5'h00;
        d.hclr = 1'b0;
        ev[IRQ_HCLR] = 1'b1;
      end
      if (q.init) begin
        d.spd[0] = DEF_SPD_INT;
        d.spd[1] = DEF_SPD_LO;
        d.spd[2] = DEF_SPD_HI;
        d.spd[3] = DEF_SPD_MATCH;
        d.num = DEF_SCALE;
        d.den = DEF_SCALE;
        d.hclr = 1'b0;
        d.uvsel = 1'b0;
        d.rtsel = 1'b0;
        d.rtime = DEF_RT_TIME;
        d.init = 1'b0;
        d.copy = COPY_NONE;
        d.prm_rst = 1'b1;
      end
    end

    // Motor enable follows run, trip and coast
    d.motor_en = i_run_cmd && !d.trip && !d.coast;

    // Scaling scan over the four speeds
    case (q.scan)
      SC_IDLE: begin
        d.start = 1'b1;
        d.scan = SC_WAIT;
      end
      SC_WAIT: begin
        if (sc.done) begin
          d.scl[q.sidx] = sc.result;
          d.sidx = q.sidx + 2'h1;
          d.scan = SC_IDLE;
        end
      end
      default: begin
        d.scan = SC_IDLE;
      end
    endcase

    // Interrupts: read clears, a new event wins
    if (i_rd && ridx == IDX_IRQ_ST) begin
      d.irq_st = 4'h0;
    end
    d.irq_st = d.irq_st | ev;
    d.irq = |(d.irq_st & d.irq_mask);
  end

  // State register with synchronous reset
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      q <= '0;
      q.spd[2] <= DEF_SPD_HI;
      q.spd[3] <= DEF_SPD_MATCH;
      q.num <= DEF_SCALE;
      q.den <= DEF_SCALE;
      q.rtime <= DEF_RT_TIME;
      q.scan <= SC_IDLE;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign o_rdata = q.rdata;
  assign o_trip = q.trip;
  assign o_coast = q.coast;
  assign o_motor_en = q.motor_en;
  assign o_prm_rst = q.prm_rst;
  assign o_copy_mode = q.copy;
  assign o_irq = q.irq;
endmodule

/* tb/mth_trip_ctrl_chk.sv */
// Checker: port-level properties of the trip history block
`timescale 1ns/1ns
module mth_trip_ctrl_chk
  import mth_pkg::*;
#(
  parameter int P_SEC_CYCLES = SEC_CYCLES
)
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [AW-1:0] i_addr,
  input wire logic [DW-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [DW-1:0] o_rdata,
  input wire logic i_trip_evt,
  input wire logic i_pwr_on,
  input wire logic o_trip,
  input wire logic o_coast,
  input wire logic o_motor_en,
  input wire logic o_prm_rst,
  input wire logic [1:0] o_copy_mode
);
  logic [31:0] hi_q;
  logic [31:0] hi_d;
  // Counts cycles the trip stays latched
  always_comb hi_d = o_trip ? hi_q + 32'h0000_0001 : 32'h0000_0000;
  always_ff @(posedge i_clk) hi_q <= i_rst_b ? hi_d : 32'h0000_0000;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  rd_idle_zero_a: assert property (!$past(i_rd) |-> o_rdata == '0)
    else $error("read data not zero outside answer cycle");
  rd_unmapped_a: assert property (i_rd && i_addr[9:2] == 8'h7f |=> o_rdata == '0)
    else $error("unmapped read not zero");
  trip_latch_a: assert property (i_trip_evt && !o_trip |=> o_trip)
    else $error("trip event not latched");
  trip_wait_a: assert property ($fell(o_trip) && !$past(i_wr) && !$past(i_pwr_on) |->
    hi_q >= P_SEC_CYCLES - 1)
    else $error("trip cleared before retrial delay");
  trip_clear_a: assert property (i_wr && i_addr[9:2] == IDX_CTRL
    && i_wdata[CTRL_TRIP_RST] && !i_trip_evt |=> !o_trip)
    else $error("trip not cleared by control write");
  motor_gate_a: assert property (o_motor_en |-> !o_trip && !o_coast)
    else $error("motor enabled while tripped or coasting");
  prm_pulse_a: assert property (o_prm_rst |=> !o_prm_rst)
    else $error("default restore pulse too long");
  prm_cause_a: assert property (o_prm_rst |-> $past(i_pwr_on))
    else $error("default restore without power-up");
  copy_out_a: assert property (i_wr && i_addr[9:2] == IDX_COPY |=> ##1
    o_copy_mode == $past(i_wdata[1:0], 2))
    else $error("copy mode output wrong");
  cover property ($rose(o_trip));
  cover property ($rose(o_coast));
  cover property (o_prm_rst);
endmodule
bind mth_trip_ctrl mth_trip_ctrl_chk #(.P_SEC_CYCLES(P_SEC_CYCLES)) chk_i (.i_clk(i_clk),
  .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .i_trip_evt(i_trip_evt), .i_pwr_on(i_pwr_on), .o_trip(o_trip),
  .o_coast(o_coast), .o_motor_en(o_motor_en), .o_prm_rst(o_prm_rst),
  .o_copy_mode(o_copy_mode));

/* tb/mth_keypad.sv */
// Operator keypad model: parameter accesses on the register bus
`timescale 1ns/1ns
module mth_keypad
  import mth_pkg::*;
(
  input wire logic i_clk,
  input wire logic [DW-1:0] i_rdata,
  output logic [AW-1:0] o_addr,
  output logic [DW-1:0] o_wdata,
  output logic o_wr,
  output logic o_rd
);
  // Idle bus at time zero
  initial begin
    o_addr = '0;
    o_wdata = '0;
    o_wr = 1'h0;
    o_rd = 1'h0;
  end
  // One-cycle write, bus scrambled once released
  task automatic wr(input logic [7:0] idx, input logic [DW-1:0] v);
    @(posedge i_clk);
    o_addr <= {idx, 2'h0};
    o_wdata <= v;
    o_wr <= 1'h1;
    @(posedge i_clk);
    o_wr <= 1'h0;
    o_addr <= ~o_addr;
    o_wdata <= ~v;
  endtask
  // One-cycle read, data taken in the answer cycle
  task automatic rd(input logic [7:0] idx, output logic [DW-1:0] v);
    @(posedge i_clk);
    o_addr <= {idx, 2'h0};
    o_rd <= 1'h1;
    @(posedge i_clk);
    o_rd <= 1'h0;
    o_addr <= ~o_addr;
    #1 v = i_rdata;
  endtask
  task automatic copy_sel(input logic [1:0] m);
    wr(IDX_COPY, {14'h0000, m});
  endtask
endmodule

/* tb/mth_trip_ctrl_tb.sv */
// Self-checking bench of the trip history block
`timescale 1ns/1ns
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin miscompares++; \
  $display("MISMATCH %0t got %h exp %h", $time, (a), (b)); end end
module mth_trip_ctrl_tb
  import mth_pkg::*;
;
  logic clk = 1'h0;
  logic rst_b = 1'h0;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata, rdata, d, n, q, hi;
  logic [DW-1:0] hist[5];
  logic [31:0] seed = 32'h734a_c318;
  logic wr, rd, trip, coast, men, prm, irq;
  logic uv = 1'h0;
  logic tevt = 1'h0;
  logic poff = 1'h0;
  logic pon = 1'h0;
  logic run = 1'h0;
  logic [3:0] tcode = 4'h0;
  logic [3:0] c;
  logic [1:0] cmode;
  int miscompares = 0;
  int num_checks = 0;
  int prm_seen = 0;
  int w, e;
  int rts[3] = '{0, 3, 121};
  always #50 clk = ~clk;
  always @(posedge clk) if (prm) prm_seen++;
  mth_trip_ctrl #(.P_SEC_CYCLES(10)) mth_trip_ctrl_i (.i_clk(clk), .i_rst_b(rst_b),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_uv(uv),
    .i_run_cmd(run), .i_trip_evt(tevt), .i_trip_code(tcode), .i_pwr_off(poff),
    .i_pwr_on(pon), .o_trip(trip), .o_coast(coast), .o_motor_en(men), .o_prm_rst(prm),
    .o_copy_mode(cmode), .o_irq(irq));
  mth_keypad mth_keypad_i (.i_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata),
    .o_wr(wr), .o_rd(rd));
  // Repeatable random source
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Expected scaling validity and scaled value
  function automatic logic sok(logic [15:0] nu, logic [15:0] de);
    return de != 16'h0000 && 32'(nu) <= 32'(de) * SCALE_MAX && 32'(nu) * SCALE_MIN_DIV >= 32'(de);
  endfunction
  function automatic logic [15:0] exp_scl(logic [15:0] v, logic [15:0] nu, logic [15:0] de);
    logic [47:0] p;
    if (!sok(nu, de)) return v;
    p = 48'(v) * 48'(nu) / 48'(de);
    return p > 48'h0000_0000_ffff ? 16'hffff : p[15:0];
  endfunction
  // History model, newest first
  function automatic void push(logic [15:0] cc);
    for (int k = 4; k > 0; k--) hist[k] = hist[k-1];
    hist[0] = cc;
  endfunction
  task automatic chk_rd(input logic [7:0] i, input logic [DW-1:0] x);
    mth_keypad_i.rd(i, d);
    `CHK(d, x);
  endtask
  task automatic trip_pulse(input logic [3:0] cc);
    @(posedge clk);
    tevt <= 1'h1;
    tcode <= cc;
    @(posedge clk);
    tevt <= 1'h0;
  endtask
  // Power removed, supply restored, power reapplied
  task automatic power_cycle();
    @(posedge clk);
    poff <= 1'h1;
    @(posedge clk);
    poff <= 1'h0;
    repeat (3) @(posedge clk);
    uv <= 1'h0;
    pon <= 1'h1;
    @(posedge clk);
    pon <= 1'h0;
    repeat (4) @(negedge clk);
  endtask
  task automatic hist_all();
    for (int k = 0; k < 5; k++) chk_rd(IDX_HIST1 + 8'(k), hist[k]); // shift order
  endtask
  task automatic tally_and_finish();
    if (miscompares == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Watchdog against a hung handshake
  initial begin
    #(30000 * 100);
    miscompares++;
    tally_and_finish();
  end
  initial begin
    for (int k = 0; k < 5; k++) hist[k] = HIST_EMPTY;
    repeat (8) @(posedge clk);
    rst_b <= 1'h1;
    run <= 1'h1;
    mth_keypad_i.rd(8'h7f, d);
    hist_all(); // empty slots
    // Every copy choice reaches the output
    for (int m = 0; m < 4; m++) begin
      mth_keypad_i.copy_sel(2'(m));
      repeat (2) @(negedge clk);
      `CHK(cmode, 2'(m)); // copy mode
    end
    // Random trips, a second event while latched is refused
    for (int t = 0; t < 7; t++) begin
      c = 4'(xs() % 11) + 4'h3;
      trip_pulse(c);
      push({12'h000, c});
      trip_pulse(4'he);
      @(negedge clk);
      `CHK({trip, men}, 2'h2); // trip latched
      mth_keypad_i.wr(IDX_CTRL, 16'h0001);
    end
    hist_all(); // newest first
    // Scaling: boundaries, saturation, out of range, random
    hi = 16'h9c40;
    mth_keypad_i.wr(IDX_SPD_HI, hi);
    for (int s = 0; s < 9; s++) begin
      n = s == 1 || s == 2 ? 16'h0001 : s == 3 ? 16'h000a : s == 4 ? 16'h000b : 16'(xs() % 30);
      q = s == 1 ? 16'h03e8 : s == 2 ? 16'h03e9 : s > 2 && s < 5 ? 16'h0001 : 16'(xs() % 30);
      mth_keypad_i.wr(IDX_SCALE_NUM, n);
      mth_keypad_i.wr(IDX_SCALE_DEN, q);
      repeat (200) @(posedge clk);
      chk_rd(IDX_SPD_HI, exp_scl(hi, n, q)); // scaled upper
      chk_rd(IDX_SPD_MATCH, exp_scl(DEF_SPD_MATCH, n, q)); // scaled match
      mth_keypad_i.rd(IDX_STATUS, d);
      `CHK(d[ST_SCALE_OK], sok(n, q)); // factor range
    end
    // Undervoltage with trip off: coast, then restart
    @(posedge clk) uv <= 1'h1;
    repeat (4) @(negedge clk);
    `CHK({trip, coast, men}, 3'h2); // coasting
    @(posedge clk) uv <= 1'h0;
    repeat (4) @(negedge clk);
    `CHK({coast, men}, 2'h1); // restart
    // No run command, no motor enable
    @(posedge clk) run <= 1'h0;
    repeat (2) @(negedge clk);
    `CHK(men, 1'h0); // restart needs run
    @(posedge clk) run <= 1'h1;
    // Undervoltage trip, brief dip then ordinary power-off
    mth_keypad_i.wr(IDX_UV_SEL, 16'h0001);
    for (int p = 0; p < 2; p++) begin
      @(posedge clk) uv <= 1'h1;
      repeat (4) @(negedge clk);
      `CHK(trip, 1'h1); // trip output
      chk_rd(IDX_STATUS, 16'h0021 | 16'(sok(n, q)) << ST_SCALE_OK); // cause code
      if (p == 1) power_cycle();
      @(posedge clk) uv <= 1'h0;
      repeat (4) @(negedge clk);
      if (p == 0) push({12'h000, CAUSE_UV});
      hist_all(); // logged on dip only
      mth_keypad_i.wr(IDX_CTRL, 16'h0001);
    end
    // Retrial: clamped waits, masked trip and unmasked retrial interrupts
    mth_keypad_i.rd(IDX_IRQ_ST, d);
    mth_keypad_i.wr(IDX_IRQ_MASK, 16'h0002);
    mth_keypad_i.wr(IDX_RT_SEL, 16'h0001);
    for (int r = 0; r < 3; r++) begin
      mth_keypad_i.wr(IDX_RT_TIME, 16'(rts[r]));
      trip_pulse(4'h4);
      push(16'h0004);
      @(negedge clk);
      `CHK(irq, 1'h0); // trip masked
      w = 1;
      while (trip === 1'h1 && w < 1500) begin
        @(negedge clk);
        w++;
      end
      e = (rts[r] == 0 ? 1 : rts[r] > 120 ? 120 : rts[r]) * 10;
      `CHK(w inside {[e - 2:e + 2]}, 1'h1); // retrial delay
      @(negedge clk);
      `CHK({trip, irq}, 2'h1); // cleared, irq
      mth_keypad_i.rd(IDX_IRQ_ST, d);
      `CHK(d[IRQ_RETRY], 1'h1); // status bit
      @(negedge clk);
      `CHK(irq, 1'h0); // read clears
    end
    // Overcurrent stays latched past the longest wait
    trip_pulse(CAUSE_OC);
    push({12'h000, CAUSE_OC});
    repeat (1300) @(negedge clk);
    `CHK(trip, 1'h1); // no retrial
    mth_keypad_i.wr(IDX_CTRL, 16'h0001);
    hist_all(); // after retrials
    // History clear across a power cycle
    mth_keypad_i.wr(IDX_HIST_CLR, 16'h0001);
    power_cycle();
    for (int k = 0; k < 5; k++) hist[k] = HIST_EMPTY;
    hist_all(); // all erased
    chk_rd(IDX_HIST_CLR, 16'h0000); // selection back
    trip_pulse(4'h6);
    @(negedge clk);
    `CHK(trip, 1'h1); // normal operation
    mth_keypad_i.wr(IDX_CTRL, 16'h0001);
    // Factory defaults across a power cycle
    mth_keypad_i.wr(IDX_SCALE_NUM, 16'h0007);
    mth_keypad_i.wr(IDX_INIT_SEL, 16'h0001);
    prm_seen = 0;
    power_cycle();
    `CHK(prm_seen, 1); // one restore pulse
    chk_rd(IDX_SCALE_NUM, DEF_SCALE); // numerator default
    repeat (200) @(posedge clk);
    chk_rd(IDX_SPD_HI, DEF_SPD_HI); // speed default
    chk_rd(IDX_RT_SEL, 16'h0000); // selection default
    tally_and_finish();
  end
endmodule
